// ---- logic/wsc_regs.sv ----
`timescale 1ns/1ps
`include "wsc_consts.svh"
module wsc_regs
  import wsc_pkg::*;
(
  input wire logic clk_i,                 // 40 MHz clock
  input wire logic rst_b_i,               // async reset, active low
  input wire wsc_pkg::wsc_req_t req_i,    // register access request
  input wire logic soft_rst_i,            // soft reset pulse
  input wire logic restart_i,             // restart entry pulse
  input wire logic fail_safe_i,           // fail-safe entry pulse
  input wire logic stop_mode_i,           // device in stop mode
  input wire logic normal_mode_i,         // device in normal mode
  input wire logic dog_load_i,            // hardware update of dog bit
  input wire logic dog_val_i,             // value for that update
  input wire wsc_pkg::wsc_src_t evt_i,    // filtered wake events
  input wire logic [2:0] hv_level_i,      // wake input levels
  input wire logic status_evt_i,          // other status bit set
  output logic [7:0] rdata_o,             // read data
  output logic wake_o,                    // wake request pulse
  output wsc_pkg::wsc_src_t wake_src_o,   // accepted sources
  output logic int_o,                     // interrupt pulse
  output logic meas_en_o,                 // measurement running
  output logic dog_off_o,                 // watchdog switched off
  output wsc_pkg::wsc_pull_ctl_t pull_o,  // pull resistor controls
  output logic [2:0] input_level_status_o, // reported levels
  output logic bus_fs_load_o,             // bus control reload pulse
  output logic [7:0] bus_fs_val_o,        // bus reload value
  output logic [7:0] bus_fs_mask_o        // bus bits to reload
);
  import wsc_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] int_ctrl;
  logic [7:0] ext_ctrl;
  logic [7:0] pull_ctrl;
  logic wr_int;
  logic wr_ext;
  logic wr_pull;

  assign wr_int = req_i.wr && (req_i.addr == `WSC_ADDR_INT);
  assign wr_ext = req_i.wr && (req_i.addr == `WSC_ADDR_EXT);
  assign wr_pull = req_i.wr && (req_i.addr == `WSC_ADDR_PULL);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_ctrl <= `WSC_INT_RST;
    end else if (soft_rst_i) begin
      int_ctrl <= `WSC_INT_RST;
    end else if (wr_int) begin
      int_ctrl <= req_i.wdata & `WSC_INT_MASK;
    end else if (dog_load_i) begin
      int_ctrl[`WSC_INT_DOG_BIT] <= dog_val_i;
    end
  end

  // fail-safe outranks soft reset, which outranks restart and writes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_ctrl <= `WSC_EXT_RST;
    end else if (fail_safe_i) begin
      ext_ctrl <= (ext_ctrl & `WSC_EXT_FS_KEEP) | `WSC_EXT_FS_SET;
    end else if (soft_rst_i) begin
      ext_ctrl <= `WSC_EXT_RST;
    end else if (restart_i) begin
      ext_ctrl <= ext_ctrl & `WSC_EXT_RESTART_KEEP;
    end else if (wr_ext) begin
      ext_ctrl <= req_i.wdata & `WSC_EXT_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pull_ctrl <= `WSC_PULL_RST;
    end else if (soft_rst_i) begin
      pull_ctrl <= `WSC_PULL_RST;
    end else if (wr_pull) begin
      pull_ctrl <= req_i.wdata & `WSC_PULL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // read port, one cycle latency, unmapped reads zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      case (req_i.addr)
        `WSC_ADDR_INT: rdata_o <= int_ctrl & `WSC_INT_MASK;
        `WSC_ADDR_EXT: rdata_o <= ext_ctrl & `WSC_EXT_MASK;
        `WSC_ADDR_PULL: rdata_o <= pull_ctrl & `WSC_PULL_MASK;
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // wake gating
  // ----------------------------------------------------------------
  logic meas;
  logic [2:0] hv_allow;
  logic [1:0] t_allow;
  logic wake_any;

  assign meas = ext_ctrl[`WSC_EXT_MEAS_BIT];
  assign hv_allow[0] = ext_ctrl[`WSC_EXT_IN1_BIT] & ~meas;
  assign hv_allow[1] = ext_ctrl[`WSC_EXT_IN2_BIT] & ~meas;
  assign hv_allow[2] = ext_ctrl[`WSC_EXT_IN3_BIT];
  assign t_allow[0] = int_ctrl[`WSC_INT_T1_BIT];
  assign t_allow[1] = int_ctrl[`WSC_INT_T2_BIT];
  assign wake_any = |({evt_i.t2, evt_i.t1} & t_allow)
                  | |(evt_i.hv & hv_allow);

  logic [2:0] hv_acc;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_in
      wsc_wake_input u_in (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .evt_i(evt_i.hv[gi]),
        .allow_i(hv_allow[gi]),
        .pull_i(wsc_pull_t'(pull_ctrl[gi*`WSC_PULL_W +: `WSC_PULL_W])),
        .level_i(hv_level_i[gi]),
        .level_hide_i(meas && (gi < 2)),
        .accept_o(hv_acc[gi]),
        .up_o(pull_o.up[gi]),
        .down_o(pull_o.down[gi]),
        .auto_o(pull_o.auto_sw[gi]),
        .level_o(input_level_status_o[gi])
      );
    end
  endgenerate

  logic t1_acc;
  logic t2_acc;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      t1_acc <= 1'b0;
      t2_acc <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      t1_acc <= evt_i.t1 & t_allow[0];
      t2_acc <= evt_i.t2 & t_allow[1];
      wake_o <= wake_any;
    end
  end
  assign wake_src_o = '{t2: t2_acc, t1: t1_acc, hv: hv_acc};

  // ----------------------------------------------------------------
  // interrupt, mode outputs, fail-safe bus reload
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_o <= 1'b0;
    end else begin
      int_o <= wake_any
             | (ext_ctrl[`WSC_EXT_GLOBAL_BIT] & status_evt_i);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meas_en_o <= 1'b0;
      dog_off_o <= 1'b0;
    end else begin
      meas_en_o <= meas & normal_mode_i;
      dog_off_o <= stop_mode_i & int_ctrl[`WSC_INT_DOG_BIT];
    end
  end

  // bus wake capability lives in the bus control register outside
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_fs_load_o <= 1'b0;
      bus_fs_val_o <= 8'h00;
      bus_fs_mask_o <= 8'h00;
    end else begin
      bus_fs_load_o <= fail_safe_i;
      bus_fs_val_o <= `WSC_BUS_FS_VAL;
      bus_fs_mask_o <= `WSC_BUS_FS_MASK;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  t2_wake_gate_a: assert property (
    evt_i.t2 |=> (wake_src_o.t2 == $past(int_ctrl[7])))
    else $error("second timer wake gating wrong");
  t1_wake_gate_a: assert property (
    evt_i.t1 && !int_ctrl[6] |=> !wake_src_o.t1)
    else $error("first timer woke while disabled");
  reserved_read_a: assert property (
    req_i.rd && req_i.addr == `WSC_ADDR_INT |=> (rdata_o & 8'h3b) == 8'h00)
    else $error("reserved bits read nonzero");
  dog_stop_off_a: assert property (
    stop_mode_i && int_ctrl[2] |=> dog_off_o ##1 (dog_off_o == $past(
      stop_mode_i && int_ctrl[2])))
    else $error("watchdog stop control wrong");
  int_policy_a: assert property (
    status_evt_i && !ext_ctrl[7] && !wake_any |=> !int_o)
    else $error("interrupt raised by status without global");
  meas_block_a: assert property (
    meas |=> !wake_src_o.hv[0] && !wake_src_o.hv[1])
    else $error("input one or two woke in measure mode");
  meas_run_a: assert property (
    ##1 meas_en_o == $past(meas && normal_mode_i))
    else $error("measurement enable wrong");
  in3_gate_a: assert property (
    evt_i.hv[2] |=> wake_src_o.hv[2] == $past(ext_ctrl[2]))
    else $error("input three gating wrong");
  in2_gate_a: assert property (
    evt_i.hv[1] && ext_ctrl[1] && !meas |=> wake_src_o.hv[1] && wake_o)
    else $error("input two wake lost");
  in1_gate_a: assert property (
    evt_i.hv[0] && !ext_ctrl[0] |=> !wake_src_o.hv[0])
    else $error("input one woke while disabled");
  fail_safe_a: assert property (
    fail_safe_i |=> ext_ctrl[3:0] == 4'h7 && !ext_ctrl[6] && bus_fs_load_o)
    else $error("fail-safe reload wrong");
  pull_dec_a: assert property (
    ##1 pull_o.down[2] == ($past(pull_ctrl[5:4]) == 2'h1)
      && pull_o.up[0] == ($past(pull_ctrl[1:0]) == 2'h2))
    else $error("pull decode wrong");
  soft_reset_a: assert property (
    soft_rst_i && !fail_safe_i |=> ext_ctrl == 8'h07)
    else $error("soft reset value wrong");
  wake_cause_a: assert property (
    wake_o |-> $past(wake_any))
    else $error("wake without enabled event");

  t2_wake_c: cover property (evt_i.t2 && int_ctrl[7] ##1 wake_o);
  meas_blocked_c: cover property (meas && evt_i.hv[0] ##1 !wake_o);
  fail_safe_c: cover property (fail_safe_i ##1 bus_fs_load_o);
  global_int_c: cover property (status_evt_i && ext_ctrl[7] ##1 int_o);

endmodule

// ---- logic/wsc_consts.svh ----
`ifndef WSC_CONSTS_SVH
`define WSC_CONSTS_SVH

// register offsets on the serial control port
`define WSC_ADDR_INT 7'h06
`define WSC_ADDR_EXT 7'h07
`define WSC_ADDR_PULL 7'h08

// internal wake control fields
`define WSC_INT_T2_BIT 7
`define WSC_INT_T1_BIT 6
`define WSC_INT_DOG_BIT 2
`define WSC_INT_MASK 8'hc4
`define WSC_INT_RST 8'h00

// external wake control fields
`define WSC_EXT_GLOBAL_BIT 7
`define WSC_EXT_MEAS_BIT 5
`define WSC_EXT_IN3_BIT 2
`define WSC_EXT_IN2_BIT 1
`define WSC_EXT_IN1_BIT 0
`define WSC_EXT_MASK 8'ha7
`define WSC_EXT_RST 8'h07
`define WSC_EXT_RESTART_KEEP 8'ha7
`define WSC_EXT_FS_KEEP 8'hb0
`define WSC_EXT_FS_SET 8'h07

// pull control fields, two bits per input from bit 0 upward
`define WSC_PULL_W 2
`define WSC_PULL_MASK 8'h3f
`define WSC_PULL_RST 8'h00

// fail-safe pattern for the bus control register
`define WSC_BUS_FS_VAL 8'h09
`define WSC_BUS_FS_MASK 8'h1f

`endif

// ---- logic/wsc_pkg.sv ----
package wsc_pkg;

  typedef enum logic [1:0] {
    WSC_PULL_NONE = 2'h0,
    WSC_PULL_DOWN = 2'h1,
    WSC_PULL_UP = 2'h2,
    WSC_PULL_AUTO = 2'h3
  } wsc_pull_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } wsc_req_t;

  typedef struct packed {
    logic t2;
    logic t1;
    logic [2:0] hv;
  } wsc_src_t;

  typedef struct packed {
    logic [2:0] up;
    logic [2:0] down;
    logic [2:0] auto_sw;
  } wsc_pull_ctl_t;

endpackage

// ---- logic/wsc_wake_input.sv ----
`timescale 1ns/1ps
module wsc_wake_input
  import wsc_pkg::*;
(
  input wire logic clk_i,               // system clock
  input wire logic rst_b_i,             // async reset, active low
  input wire logic evt_i,               // filtered wake event
  input wire logic allow_i,             // input may wake now
  input wire wsc_pkg::wsc_pull_t pull_i, // pull field
  input wire logic level_i,             // input level
  input wire logic level_hide_i,        // report level as zero
  output logic accept_o,                // accepted wake pulse
  output logic up_o,                    // pull-up enable
  output logic down_o,                  // pull-down enable
  output logic auto_o,                  // automatic pull switching
  output logic level_o                  // reported level
);
  import wsc_pkg::*;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      accept_o <= 1'b0;
    end else begin
      accept_o <= evt_i & allow_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      up_o <= 1'b0;
      down_o <= 1'b0;
      auto_o <= 1'b0;
    end else begin
      up_o <= (pull_i == WSC_PULL_UP);
      down_o <= (pull_i == WSC_PULL_DOWN);
      auto_o <= (pull_i == WSC_PULL_AUTO);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_o <= 1'b0;
    end else begin
      level_o <= level_i & ~level_hide_i;
    end
  end

endmodule

// ---- sim/wsc_host_model.sv ----
`timescale 1ns/1ps
module wsc_host_model (
  input wire logic clk_i,          // system clock
  input wire logic [7:0] rdata_i,  // read data from the block
  output wsc_pkg::wsc_req_t req_o  // register access request
);
  import wsc_pkg::*;
  // the bus control register lives outside this block
  initial req_o = '{wr: 1'b0, rd: 1'b0, addr: 7'h7f, wdata: 8'h55};

  // one byte write, strobe held for one edge, then scrambled
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
  endtask

  // one byte read, data taken after the answering edge
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    #1 v = rdata_i;
  endtask
endmodule

// ---- sim/wake_source_control_regs_tb_top.sv ----
`timescale 1ns/1ps
module wake_source_control_regs_tb_top;
  import wsc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sr = 1'b0, rs = 1'b0, fs = 1'b0, stp = 1'b0, nrm = 1'b0, st = 1'b0;
  logic [2:0] lvl = 3'h0;
  logic dl = 1'b0, dv = 1'b0;
  wsc_src_t ev = '0;
  wsc_req_t req;
  wsc_src_t src;
  wsc_pull_ctl_t pull;
  logic [7:0] rdata, fsv, fsm, d;
  logic wake, irq, meas, dog, fsl;
  logic [2:0] lst;
  int mismatches = 0;
  int checked = 0;
  logic [7:0] cfg [5] = '{8'h07, 8'h01, 8'h02, 8'h04, 8'h27};
  logic [4:0] xs [5] = '{5'h07, 5'h01, 5'h02, 5'h04, 5'h04};

  always #12.5 clk = ~clk;

  wsc_host_model wsc_host_model_inst (.clk_i(clk), .rdata_i(rdata),
    .req_o(req));
  wsc_regs wsc_regs_inst (.clk_i(clk), .rst_b_i(rst_b), .req_i(req),
    .soft_rst_i(sr), .restart_i(rs), .fail_safe_i(fs), .stop_mode_i(stp),
    .normal_mode_i(nrm), .dog_load_i(dl), .dog_val_i(dv), .evt_i(ev),
    .hv_level_i(lvl), .status_evt_i(st), .rdata_o(rdata), .wake_o(wake),
    .wake_src_o(src), .int_o(irq), .meas_en_o(meas), .dog_off_o(dog),
    .pull_o(pull), .input_level_status_o(lst), .bus_fs_load_o(fsl),
    .bus_fs_val_o(fsv), .bus_fs_mask_o(fsm));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic w(input logic [6:0] a, input logic [7:0] v);
    wsc_host_model_inst.wr(a, v);
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    wsc_host_model_inst.rd(a, d);
    chk("rdata", {8'h0, e}, {8'h0, d});
  endtask

  task automatic kick(input wsc_src_t e, input logic s,
                      input logic [4:0] x, input logic xi);
    @(posedge clk);
    ev <= e;
    st <= s;
    @(posedge clk);
    ev <= '0;
    st <= 1'b0;
    #1 chk("wake", {15'h0, |x}, {15'h0, wake});
    chk("src", {11'h0, x}, {11'h0, src});
    chk("int", {15'h0, xi}, {15'h0, irq});
  endtask

  task automatic ctl(input logic [2:0] c);
    @(posedge clk);
    {fs, sr, rs} <= c;
    @(posedge clk);
    {fs, sr, rs} <= 3'h0;
    #1 chk("fs_load", {15'h0, c[2]}, {15'h0, fsl});
  endtask

  // lets level outputs follow their inputs before they are compared
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_access;
    rchk(7'h07, 8'h07);
    rchk(7'h06, 8'h00);
    rchk(7'h08, 8'h00);
    w(7'h06, 8'hff);
    w(7'h07, 8'hff);
    w(7'h08, 8'hff);
    w(7'h09, 8'hff);
    rchk(7'h06, 8'hc4);
    rchk(7'h07, 8'ha7);
    rchk(7'h08, 8'h3f);
    rchk(7'h09, 8'h00);
    $display("access done");
  endtask

  task automatic t_timer;
    w(7'h06, 8'h80);
    kick(5'h18, 1'b0, 5'h10, 1'b1);
    w(7'h06, 8'h40);
    kick(5'h18, 1'b0, 5'h08, 1'b1);
    w(7'h06, 8'h00);
    kick(5'h18, 1'b0, 5'h00, 1'b0);
    $display("timer done");
  endtask

  task automatic t_inputs;
    for (int i = 0; i < 5; i++) begin
      w(7'h07, cfg[i]);
      kick(5'h07, 1'b0, xs[i], 1'b1);
    end
    @(posedge clk);
    nrm <= 1'b1;
    lvl <= 3'h7;
    settle();
    chk("meas", 16'h1, {15'h0, meas});
    chk("lvl", 16'h4, {13'h0, lst});
    @(posedge clk);
    nrm <= 1'b0;
    settle();
    chk("meas", 16'h0, {15'h0, meas});
    $display("inputs done");
  endtask

  task automatic t_global;
    w(7'h07, 8'h00);
    kick(5'h00, 1'b1, 5'h00, 1'b0);
    w(7'h07, 8'h80);
    kick(5'h00, 1'b1, 5'h00, 1'b1);
    $display("global done");
  endtask

  task automatic t_dog_pull;
    w(7'h06, 8'h04);
    stp <= 1'b1;
    settle();
    chk("dog", 16'h1, {15'h0, dog});
    w(7'h06, 8'h00);
    settle();
    chk("dog", 16'h0, {15'h0, dog});
    @(posedge clk);
    dl <= 1'b1;
    dv <= 1'b1;
    @(posedge clk);
    dl <= 1'b0;
    dv <= 1'b0;
    rchk(7'h06, 8'h04);
    chk("dog", 16'h1, {15'h0, dog});
    w(7'h08, 8'h1b);
    settle();
    chk("pull", {7'h0, 9'b010_100_001}, {7'h0, pull});
    w(7'h08, 8'h24);
    settle();
    chk("pull", {7'h0, 9'b100_010_000}, {7'h0, pull});
    $display("dog and pull done");
  endtask

  task automatic t_modes;
    w(7'h07, 8'ha0);
    ctl(3'b100);
    chk("fs_val", 16'h09, {8'h0, fsv});
    chk("fs_mask", 16'h1f, {8'h0, fsm});
    rchk(7'h07, 8'ha7);
    w(7'h07, 8'h25);
    w(7'h06, 8'hc0);
    ctl(3'b001);
    rchk(7'h07, 8'h25);
    ctl(3'b010);
    rchk(7'h07, 8'h07);
    rchk(7'h06, 8'h00);
    rchk(7'h08, 8'h00);
    $display("modes done");
  endtask

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_access();
    t_timer();
    t_inputs();
    t_global();
    t_dog_pull();
    t_modes();
    test_done();
  end

  // run is about 120 cycles; this cuts a hang short
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule
